// ==== rtl/icr_buf2.sv ====
// Purpose: Two-entry valid/ready buffer for read bytes.
// Assumes: Single clock, source and sink on the same domain.
// Notes: Width is fixed at one byte, depth two.
`timescale 1ns/10ps
`default_nettype none
module icr_buf2 (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [7:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in,
  input wire logic flush_in
);
  import icr_pkg::*;
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic rd;
    logic wr;
    logic [1:0] cnt;
  } icr_buf_t;
  icr_buf_t s_r, s_nxt;
  logic push, pop;

  // Honest full and empty from the occupancy count
  assign in_ready_out = (s_r.cnt != 2'd2);
  assign out_valid_out = (s_r.cnt != 2'd0);
  assign out_data_out = s_r.mem[s_r.rd];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  // Next state of the ring
  always_comb begin
    s_nxt = s_r;
    if (flush_in) begin
      s_nxt.cnt = 2'd0;
      s_nxt.rd = 1'b0;
      s_nxt.wr = 1'b0;
    end else begin
      if (push) begin
        s_nxt.mem[s_r.wr] = in_data_in;
        s_nxt.wr = ~s_r.wr;
      end
      if (pop) begin
        s_nxt.rd = ~s_r.rd;
      end
      s_nxt.cnt = 2'(s_r.cnt + {1'b0, push} - {1'b0, pop});
    end
  end

  // State register
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : icr_buf2
`default_nettype wire

// ==== rtl/icr_core.sv ====
// Purpose: Run control, conversion timing and result readout over a serial bus.
// Assumes: Serial clock well below half of ref_clk_in; mode 0, MSB first.
// Notes: Conversion results come from the sensor front end as sample inputs.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Comes out of reset asleep, not converting, configuration writable.
// - Writing 0x00 to run control starts active conversion.
// - Standard ready flag sits at bit 6 of flags register 0x20.
// - Loss result: low byte 0x21, high byte 0x22.
// - Inductance result: low byte 0x23, high byte 0x24.
// - Both result pairs readable in one address-incrementing transaction.
// - Fine ready flag sits at bit 0 of register 0x3b.
// - Fine result in 0x38..0x3a, readable in one transaction.
// - Fine conversion lasts 16 cycles per count unit plus 55.
// - Reference count is 16 bits, low byte 0x30, high byte 0x31.
// - Standard and fine paths run on independent schedules.
// - Supports loss plus inductance, or inductance only on fine path.
// - Active device keeps converting; host repeats wait and read.
module icr_core (
  input wire logic ref_clk_in,
  input wire logic rstn_in,
  input wire logic sclk_in,
  input wire logic csn_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic miso_oe_out,
  output logic interrupt_out_n_out,
  input wire logic [15:0] loss_sample_in,
  input wire logic [15:0] induct_sample_in,
  input wire logic [23:0] fine_sample_in,
  output logic converting_out
);
  import icr_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_DATA = 3'b011, ST_DONE = 3'b010
  } icr_state_t;
  typedef struct packed {
    logic [2:0] sck_s; logic [1:0] csn_s; logic [1:0] mosi_s;
    icr_state_t st; logic [2:0] bits; logic [7:0] shin; logic [7:0] shout;
    logic rd; logic [6:0] addr; logic load; logic pend;
    logic [7:0] loss_cfg; logic [7:0] tc1; logic [7:0] tc2; logic [7:0] dig;
    logic [7:0] run; logic [15:0] rcnt;
    logic [15:0] std_cnt; logic [19:0] fine_cnt;
    logic [15:0] loss_res; logic [15:0] ind_res; logic [23:0] fine_res;
    logic [15:0] loss_snap; logic [15:0] ind_snap; logic [23:0] fine_snap;
    logic std_rdy_n; logic fine_rdy_n; logic rd_std; logic rd_fine;
    logic miso; logic oe; logic irq_n; logic conv;
  } icr_core_t;
  icr_core_t s_r, s_nxt;
  logic sck_rise, sck_fall, cs_act, active, fine_only;
  logic [7:0] rd_byte, buf_data;
  logic buf_in_ready, buf_valid, buf_pop, std_done, fine_done;
  logic [19:0] fine_len;

  // Second sync stage and beyond feed the edge logic only
  assign sck_rise = s_r.sck_s[1] && !s_r.sck_s[2];
  assign sck_fall = !s_r.sck_s[1] && s_r.sck_s[2];
  assign cs_act = !s_r.csn_s[1];
  // Active when run code is zero
  assign active = (s_r.run[1:0] == ICR_STATE_ACTIVE);
  // Inductance-only when bit 7 of the loss configuration is set
  assign fine_only = s_r.loss_cfg[7];
  // Length 16 per count unit plus post-processing
  assign fine_len = 20'(s_r.rcnt * ICR_FINE_CYC_PER_UNIT) + 20'(ICR_FINE_POST_CYC);
  assign std_done = active && !fine_only && (s_r.std_cnt == ICR_STD_CONV_CYC - 16'd1);
  assign fine_done = active && (s_r.fine_cnt >= fine_len - 20'd1);

  // Register read mux, results from the transaction snapshot
  always_comb begin
    rd_byte = 8'h00;
    case (s_r.addr)
      ICR_ADDR_LOSS_CFG: rd_byte = s_r.loss_cfg;
      ICR_ADDR_TC_ONE: rd_byte = s_r.tc1;
      ICR_ADDR_TC_TWO: rd_byte = s_r.tc2;
      ICR_ADDR_DIG_CFG: rd_byte = s_r.dig;
      ICR_ADDR_RUN_CTL: rd_byte = s_r.run;
      ICR_ADDR_FLAGS: rd_byte = 8'(s_r.std_rdy_n) << ICR_FLAG_READY_BIT;
      ICR_ADDR_LOSS_LO: rd_byte = s_r.loss_snap[7:0];
      ICR_ADDR_LOSS_HI: rd_byte = s_r.loss_snap[15:8];
      ICR_ADDR_IND_LO: rd_byte = s_r.ind_snap[7:0];
      ICR_ADDR_IND_HI: rd_byte = s_r.ind_snap[15:8];
      ICR_ADDR_RCNT_LO: rd_byte = s_r.rcnt[7:0];
      ICR_ADDR_RCNT_HI: rd_byte = s_r.rcnt[15:8];
      ICR_ADDR_FINE_B0: rd_byte = s_r.fine_snap[7:0];
      ICR_ADDR_FINE_B1: rd_byte = s_r.fine_snap[15:8];
      ICR_ADDR_FINE_B2: rd_byte = s_r.fine_snap[23:16];
      ICR_ADDR_FINE_FLAGS: rd_byte = 8'(s_r.fine_rdy_n) << ICR_FINE_READY_BIT;
      default: rd_byte = 8'h00;
    endcase
  end

  // Read bytes pass the buffer; the shifter pops one at each byte start
  assign buf_pop = s_r.load;

  icr_buf2 u_buf (
    .ref_clk_in(ref_clk_in),
    .rstn_in(rstn_in),
    .in_data_in(rd_byte),
    .in_valid_in(s_r.pend),
    .in_ready_out(buf_in_ready),
    .out_data_out(buf_data),
    .out_valid_out(buf_valid),
    .out_ready_in(buf_pop),
    .flush_in(!cs_act)
  );

  // Whole next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.sck_s = {s_r.sck_s[1:0], sclk_in};
    s_nxt.csn_s = {s_r.csn_s[0], csn_in};
    s_nxt.mosi_s = {s_r.mosi_s[0], mosi_in};
    s_nxt.load = 1'b0;
    // One fetch per byte boundary, so the byte is buffered before the next fall
    s_nxt.pend = 1'b0;
    // Standard path counter on its own period
    if (active && !fine_only) begin
      s_nxt.std_cnt = std_done ? 16'd0 : s_r.std_cnt + 16'd1;
    end else begin
      s_nxt.std_cnt = 16'd0;
    end
    if (active) begin
      s_nxt.fine_cnt = fine_done ? 20'd0 : s_r.fine_cnt + 20'd1;
    end else begin
      s_nxt.fine_cnt = 20'd0;
    end
    // Reading a result clears its flag once the frame ends
    if (s_r.rd_std && !cs_act) s_nxt.std_rdy_n = 1'b1;
    if (s_r.rd_fine && !cs_act) s_nxt.fine_rdy_n = 1'b1;
    // Completion sets the flag, winning over a read clear
    if (std_done) begin
      s_nxt.loss_res = loss_sample_in;
      s_nxt.ind_res = induct_sample_in;
      s_nxt.std_rdy_n = 1'b0;
    end
    if (fine_done) begin
      s_nxt.fine_res = fine_sample_in;
      s_nxt.fine_rdy_n = 1'b0;
    end
    // Interrupt pin low while any result waits
    s_nxt.irq_n = s_nxt.std_rdy_n && s_nxt.fine_rdy_n;
    s_nxt.conv = active;
    if (!cs_act) begin
      s_nxt.st = ST_IDLE;
      s_nxt.oe = 1'b0;
      s_nxt.miso = 1'b0;
      // Clear flags only when the transaction ends
      s_nxt.rd_std = 1'b0;
      s_nxt.rd_fine = 1'b0;
    end else begin
      if (s_r.st == ST_IDLE) begin
        s_nxt.loss_snap = s_r.loss_res;
        s_nxt.ind_snap = s_r.ind_res;
        s_nxt.fine_snap = s_r.fine_res;
        s_nxt.st = ST_ADDR;
        s_nxt.bits = 3'd0;
        s_nxt.oe = 1'b1;
      end
      if (sck_rise && s_r.st != ST_IDLE) begin
        s_nxt.shin = {s_r.shin[6:0], s_r.mosi_s[1]};
        s_nxt.bits = s_r.bits + 3'd1;
        if (s_r.bits == 3'd7) begin
          if (s_r.st == ST_ADDR) begin
            s_nxt.rd = s_r.shin[6];
            s_nxt.pend = s_r.shin[6];
            s_nxt.addr = s_r.shin[5:0] == 6'h00 ? {s_r.shin[5:0], s_r.mosi_s[1]}
                                                : {s_r.shin[5:0], s_r.mosi_s[1]};
            s_nxt.st = ST_DATA;
          end else begin
            // Writes only land while asleep except run control
            if (!s_r.rd) begin
              case (s_r.addr)
                ICR_ADDR_LOSS_CFG: if (!active) s_nxt.loss_cfg = {s_r.shin[6:0], s_r.mosi_s[1]};
                ICR_ADDR_TC_ONE: if (!active) s_nxt.tc1 = {s_r.shin[6:0], s_r.mosi_s[1]};
                ICR_ADDR_TC_TWO: if (!active) s_nxt.tc2 = {s_r.shin[6:0], s_r.mosi_s[1]};
                ICR_ADDR_DIG_CFG: if (!active) s_nxt.dig = {s_r.shin[6:0], s_r.mosi_s[1]};
                ICR_ADDR_RUN_CTL: s_nxt.run = {s_r.shin[6:0], s_r.mosi_s[1]};
                ICR_ADDR_RCNT_LO: if (!active) s_nxt.rcnt[7:0] = {s_r.shin[6:0], s_r.mosi_s[1]};
                ICR_ADDR_RCNT_HI: if (!active) s_nxt.rcnt[15:8] = {s_r.shin[6:0], s_r.mosi_s[1]};
                default: ;
              endcase
            end else begin
              if (s_r.addr >= ICR_ADDR_LOSS_LO && s_r.addr <= ICR_ADDR_IND_HI)
                s_nxt.rd_std = 1'b1;
              if (s_r.addr >= ICR_ADDR_FINE_B0 && s_r.addr <= ICR_ADDR_FINE_B2)
                s_nxt.rd_fine = 1'b1;
            end
            s_nxt.addr = s_r.addr + 7'd1;
            s_nxt.pend = s_r.rd;
          end
        end
      end
      // Output shifting on falling edge
      if (sck_fall && s_r.st == ST_DATA) begin
        if (s_r.bits == 3'd0 && buf_valid) begin
          s_nxt.shout = {buf_data[6:0], 1'b0};
          s_nxt.miso = buf_data[7];
          s_nxt.load = 1'b1;
        end else begin
          s_nxt.shout = {s_r.shout[6:0], 1'b0};
          s_nxt.miso = s_r.shout[7];
        end
      end
    end
  end

  // State register, sleep on reset
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s_r <= '0;
      s_r.sck_s <= 3'b000;
      s_r.csn_s <= 2'b11;
      s_r.run <= ICR_RUN_CTL_RST;
      s_r.rcnt <= ICR_RCNT_RST;
      s_r.loss_cfg <= ICR_CFG_RST;
      s_r.std_rdy_n <= 1'b1;
      s_r.fine_rdy_n <= 1'b1;
      s_r.irq_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign miso_out = s_r.miso;
  assign miso_oe_out = s_r.oe;
  assign interrupt_out_n_out = s_r.irq_n;
  assign converting_out = s_r.conv;

  property p_sleep_idle;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      !active |-> ##1 (s_r.fine_cnt == 20'd0 && s_r.std_cnt == 16'd0);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("counter ran while asleep");
  // Run code zero gives converting output
  property p_active_out;
    @(posedge ref_clk_in) disable iff (!rstn_in) active |=> converting_out;
  endproperty
  a_active_out: assert property (p_active_out) else $error("converting not shown");
  // Fine completion sets the flag low next cycle
  property p_fine_flag;
    @(posedge ref_clk_in) disable iff (!rstn_in) fine_done |=> !s_r.fine_rdy_n;
  endproperty
  a_fine_flag: assert property (p_fine_flag) else $error("fine flag not set");
  property p_std_flag;
    @(posedge ref_clk_in) disable iff (!rstn_in) std_done |=> !s_r.std_rdy_n;
  endproperty
  a_std_flag: assert property (p_std_flag) else $error("std flag not set");
  property p_fine_len;
    @(posedge ref_clk_in) disable iff (!rstn_in) active |-> s_r.fine_cnt < fine_len;
  endproperty
  a_fine_len: assert property (p_fine_len) else $error("fine length exceeded");
  property p_irq;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (!s_r.std_rdy_n || !s_r.fine_rdy_n) |-> !interrupt_out_n_out;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not low");
  property p_snap;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (s_r.st != ST_IDLE && cs_act) |=> $stable(s_r.fine_snap) || !cs_act;
  endproperty
  a_snap: assert property (p_snap) else $error("snapshot moved");
  // Fine flag goes high after a read once the frame ends, unless a completion lands
  property p_clear;
    @(posedge ref_clk_in) disable iff (!rstn_in)
      (s_r.rd_fine && !cs_act && !fine_done) |=> s_r.fine_rdy_n;
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");
  property p_only;
    @(posedge ref_clk_in) disable iff (!rstn_in) fine_only |-> !std_done;
  endproperty
  a_only: assert property (p_only) else $error("std path ran");
  c_fine: cover property (@(posedge ref_clk_in) fine_done);
  c_std: cover property (@(posedge ref_clk_in) std_done);
  c_read: cover property (@(posedge ref_clk_in) s_r.rd_std && !cs_act);
endmodule : icr_core
`default_nettype wire

// ==== rtl/icr_pkg.sv ====
// Purpose: Shared constants for the inductive conversion run control block.
// Assumes: Byte-wide registers on a four-wire serial bus, mode 0, MSB first.
// Notes: Offsets are byte addresses on the serial bus.
package icr_pkg;
  localparam logic [6:0] ICR_ADDR_LOSS_CFG = 7'h01;
  localparam logic [6:0] ICR_ADDR_TC_ONE = 7'h02;
  localparam logic [6:0] ICR_ADDR_TC_TWO = 7'h03;
  localparam logic [6:0] ICR_ADDR_DIG_CFG = 7'h04;
  localparam logic [6:0] ICR_ADDR_RUN_CTL = 7'h0b;
  localparam logic [6:0] ICR_ADDR_FLAGS = 7'h20;
  localparam logic [6:0] ICR_ADDR_LOSS_LO = 7'h21;
  localparam logic [6:0] ICR_ADDR_LOSS_HI = 7'h22;
  localparam logic [6:0] ICR_ADDR_IND_LO = 7'h23;
  localparam logic [6:0] ICR_ADDR_IND_HI = 7'h24;
  localparam logic [6:0] ICR_ADDR_RCNT_LO = 7'h30;
  localparam logic [6:0] ICR_ADDR_RCNT_HI = 7'h31;
  localparam logic [6:0] ICR_ADDR_FINE_B0 = 7'h38;
  localparam logic [6:0] ICR_ADDR_FINE_B1 = 7'h39;
  localparam logic [6:0] ICR_ADDR_FINE_B2 = 7'h3a;
  localparam logic [6:0] ICR_ADDR_FINE_FLAGS = 7'h3b;
  // Field positions
  localparam int ICR_FLAG_READY_BIT = 6;
  localparam int ICR_FINE_READY_BIT = 0;
  localparam logic [1:0] ICR_STATE_ACTIVE = 2'h0;
  localparam logic [1:0] ICR_STATE_SLEEP = 2'h1;
  // Reset values
  localparam logic [7:0] ICR_RUN_CTL_RST = 8'h01;
  localparam logic [7:0] ICR_CFG_RST = 8'h00;
  localparam logic [15:0] ICR_RCNT_RST = 16'h014a;
  // Conversion timing in reference clock cycles
  localparam int ICR_FINE_CYC_PER_UNIT = 16;
  localparam logic [7:0] ICR_FINE_POST_CYC = 8'd55;
  localparam logic [15:0] ICR_STD_CONV_CYC = 16'd333;
  localparam int ICR_READ_CMD_BIT = 7;
endpackage : icr_pkg

// ==== verif/icr_core_bench.sv ====
// Purpose: Self-checking bench for the conversion run control block.
// Assumes: Host model drives the serial pins; samples come from an LFSR.
// Notes: Reference count is shrunk so fine conversions stay short.
`timescale 1ns/10ps
`default_nettype none
module icr_core_bench;
  import icr_pkg::*;
  localparam int RCNT = 8;
  localparam int FINE_CYC = ICR_FINE_CYC_PER_UNIT * RCNT + int'(ICR_FINE_POST_CYC);
  logic ref_clk_in, rstn_in, sclk_in, csn_in, mosi_in, miso_out, miso_oe_out;
  logic interrupt_out_n_out, converting_out, act;
  logic [15:0] loss_sample_in, induct_sample_in;
  logic [23:0] fine_sample_in, lfsr_r, exp_fine;
  logic [7:0] rxq [$];
  logic [7:0] mdl [128];
  int err_count, checks_done, cnt;

  icr_core i_icr_core (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .sclk_in(sclk_in),
    .csn_in(csn_in), .mosi_in(mosi_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out),
    .interrupt_out_n_out(interrupt_out_n_out), .loss_sample_in(loss_sample_in),
    .induct_sample_in(induct_sample_in), .fine_sample_in(fine_sample_in),
    .converting_out(converting_out));
  icr_host i_icr_host (.ref_clk_in(ref_clk_in), .sclk_out(sclk_in), .csn_out(csn_in),
    .mosi_out(mosi_in), .miso_in(miso_out));

  // 50 MHz reference clock
  always #10 ref_clk_in = ~ref_clk_in;

  function automatic logic [23:0] lfsr_f(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction : lfsr_f

  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic rd(input logic [6:0] a, input int n);
    logic [7:0] tq [$];
    tq = {{1'b1, a}};
    repeat (n) tq.push_back(8'h00);
    i_icr_host.xfer(tq, rxq);
  endtask : rd

  // Model: configuration lands only while asleep, run control always
  task automatic wr(input logic [6:0] a, input logic [7:0] d [$]);
    logic [7:0] tq [$];
    tq = d;
    tq.push_front({1'b0, a});
    i_icr_host.xfer(tq, rxq);
    foreach (d[i]) begin
      if (!act || a == ICR_ADDR_RUN_CTL) mdl[a + i] = d[i];
    end
    act = (mdl[ICR_ADDR_RUN_CTL][1:0] == 2'h0);
  endtask : wr

  // Bounded wait for the interrupt pin, counting clocks
  task automatic wait_irq();
    cnt = 0;
    while (interrupt_out_n_out !== 1'b0 && cnt < 4000) begin
      @(posedge ref_clk_in);
      cnt++;
    end
  endtask : wait_irq

  task automatic results();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : results

  // Watchdog sized well above the expected run
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    err_count++;
    results();
  end

  initial begin
    ref_clk_in = 1'b0;
    rstn_in = 1'b0;
    loss_sample_in = 16'h0000;
    induct_sample_in = 16'h0000;
    fine_sample_in = 24'h000000;
    lfsr_r = 24'h017fa0;
    err_count = 0;
    checks_done = 0;
    act = 1'b0;
    foreach (mdl[i]) mdl[i] = ICR_CFG_RST;
    mdl[ICR_ADDR_RUN_CTL] = ICR_RUN_CTL_RST;
    mdl[ICR_ADDR_RCNT_LO] = 8'h4a;
    mdl[ICR_ADDR_RCNT_HI] = 8'h01;
    repeat (3) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    repeat (3) @(posedge ref_clk_in);
    chk("converting", converting_out, 1'b0);
    chk("irq_n", interrupt_out_n_out, 1'b1);
    chk("miso_oe", miso_oe_out, 1'b0);
    rd(ICR_ADDR_RUN_CTL, 1);
    chk("run_control", rxq[1], mdl[ICR_ADDR_RUN_CTL]);
    rd(ICR_ADDR_RCNT_LO, 2);
    chk("ref_count", {rxq[2], rxq[1]}, 16'h014a);
    rd(7'h10, 1);
    chk("unmapped", rxq[1], 8'h00);
    rd(ICR_ADDR_FLAGS, 1);
    chk("std_ready_idle", rxq[1][ICR_FLAG_READY_BIT], 1'b1);
    // Configure while asleep, one extended write
    wr(ICR_ADDR_LOSS_CFG, {8'h36, 8'hde, 8'hfe, 8'he6});
    rd(ICR_ADDR_LOSS_CFG, 4);
    for (int i = 0; i < 4; i++) begin
      chk("config", rxq[i + 1], mdl[ICR_ADDR_LOSS_CFG + i]);
    end
    wr(ICR_ADDR_RCNT_LO, {8'h08, 8'h00});
    @(posedge ref_clk_in);
    lfsr_r = lfsr_f(lfsr_r);
    loss_sample_in <= lfsr_r[15:0];
    induct_sample_in <= lfsr_r[23:8];
    lfsr_r = lfsr_f(lfsr_r);
    fine_sample_in <= lfsr_r;
    exp_fine = lfsr_r;
    // Start, then wait on the pin instead of polling
    wr(ICR_ADDR_RUN_CTL, {8'h00});
    wait_irq();
    chk("converting", converting_out, 1'b1);
    chk("fine_time", cnt >= FINE_CYC - 16 && cnt <= FINE_CYC + 16, 1'b1);
    // Sample moves mid-read; bytes must stay from one conversion
    fork
      rd(ICR_ADDR_FINE_B0, 4);
      begin
        @(negedge csn_in);
        @(posedge ref_clk_in);
        lfsr_r = lfsr_f(lfsr_r);
        fine_sample_in <= lfsr_r;
      end
    join
    chk("fine_result", {rxq[3], rxq[2], rxq[1]}, exp_fine);
    chk("fine_ready", rxq[4][ICR_FINE_READY_BIT], 1'b0);
    exp_fine = lfsr_r;
    // Configuration refused while active
    wr(ICR_ADDR_LOSS_CFG, {8'h75});
    rd(ICR_ADDR_LOSS_CFG, 1);
    chk("cfg_locked", rxq[1], mdl[ICR_ADDR_LOSS_CFG]);
    repeat (400) @(posedge ref_clk_in);
    rd(ICR_ADDR_FLAGS, 5);
    chk("std_ready", rxq[1][ICR_FLAG_READY_BIT], 1'b0);
    chk("loss", {rxq[3], rxq[2]}, loss_sample_in);
    chk("induct", {rxq[5], rxq[4]}, induct_sample_in);
    // Conversions keep running with the new sample
    rd(ICR_ADDR_FINE_B0, 4);
    chk("fine_again", {rxq[3], rxq[2], rxq[1]}, exp_fine);
    // Back to sleep, then clear both results
    wr(ICR_ADDR_RUN_CTL, {8'h01});
    repeat (8) @(posedge ref_clk_in);
    chk("converting", converting_out, 1'b0);
    repeat (400) @(posedge ref_clk_in);
    rd(ICR_ADDR_FLAGS, 5);
    rd(ICR_ADDR_FINE_B0, 4);
    rd(ICR_ADDR_FLAGS, 1);
    chk("std_cleared", rxq[1][ICR_FLAG_READY_BIT], 1'b1);
    rd(ICR_ADDR_FINE_FLAGS, 1);
    chk("fine_cleared", rxq[1][ICR_FINE_READY_BIT], 1'b1);
    chk("irq_n", interrupt_out_n_out, 1'b1);
    // Inductance-only mode leaves the standard path idle
    wr(ICR_ADDR_LOSS_CFG, {8'hb5});
    rd(ICR_ADDR_LOSS_CFG, 1);
    chk("config", rxq[1], mdl[ICR_ADDR_LOSS_CFG]);
    wr(ICR_ADDR_RUN_CTL, {8'h00});
    repeat (400) @(posedge ref_clk_in);
    rd(ICR_ADDR_FLAGS, 1);
    chk("std_idle", rxq[1][ICR_FLAG_READY_BIT], 1'b1);
    rd(ICR_ADDR_FINE_FLAGS, 1);
    chk("fine_runs", rxq[1][ICR_FINE_READY_BIT], 1'b0);
    wr(ICR_ADDR_RUN_CTL, {8'h01});
    results();
  end
endmodule : icr_core_bench
`default_nettype wire

// ==== verif/icr_host.sv ====
// Purpose: Host side of the four-wire serial bus for the run control bench.
// Assumes: Mode 0, MSB first, serial period 160 ns (four reference clocks a half).
// Notes: Serial clock stands low outside frames; released data line toggles.
`timescale 1ns/10ps
`default_nettype none
module icr_host (
  input wire logic ref_clk_in,
  output logic sclk_out,
  output logic csn_out,
  output logic mosi_out,
  input wire logic miso_in
);
  // Idle levels from time zero
  initial begin
    sclk_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end

  // One framed transfer; every byte seen comes back, the command byte too
  task automatic xfer(input logic [7:0] tx [$], output logic [7:0] rx [$]);
    logic [7:0] b;
    rx = {};
    repeat (4) @(posedge ref_clk_in);
    csn_out <= 1'b0;
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        mosi_out <= tx[i][k];
        repeat (4) @(posedge ref_clk_in);
        // Sampled before this edge's own updates land
        b[k] = miso_in;
        sclk_out <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        sclk_out <= 1'b0;
      end
      rx.push_back(b);
    end
    repeat (4) @(posedge ref_clk_in);
    csn_out <= 1'b1;
    // A released line must not keep showing the last bit
    mosi_out <= ~mosi_out;
  endtask : xfer
endmodule : icr_host
`default_nettype wire
